// ---- design/sps_device.sv ----
`timescale 1ns/1ns
`default_nettype none

module sps_device (
	input wire logic clk_i,
	input wire logic rst_i,
	sps_link_if.device link,
	output logic [7:0] conv_enable_o,
	output logic share_present_o
);
	localparam int unsigned NC = sps_pkg::NUM_CHAN;
	localparam int unsigned NW = sps_pkg::NUM_WORDS;
	localparam int unsigned LOSS_W = 16;
	localparam logic [LOSS_W-1:0] LOSS_CYC = LOSS_W'(sps_pkg::SHARE_LOSS_CYC);
	localparam logic [9:0] OSC_LAST = 10'(sps_pkg::TICK_CYC - 1);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [7:0] ctrl_s1_q;
	logic [7:0] ctrl_s2_q;
	logic [7:0] uv_s1_q;
	logic [7:0] uv_s2_q;
	logic share_s1_q;
	logic share_s2_q;
	logic share_s3_q;

	// Two flops on the control and undervoltage pins, three on the shared line
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_s1_q <= 8'h00;
			ctrl_s2_q <= 8'h00;
			uv_s1_q <= 8'h00;
			uv_s2_q <= 8'h00;
			share_s1_q <= 1'b0;
			share_s2_q <= 1'b0;
			share_s3_q <= 1'b0;
		end else begin
			ctrl_s1_q <= link.channel_control_pin;
			ctrl_s2_q <= ctrl_s1_q;
			uv_s1_q <= link.uv_reached;
			uv_s2_q <= uv_s1_q;
			share_s1_q <= link.share_clk;
			share_s2_q <= share_s1_q;
			share_s3_q <= share_s2_q;
		end
	end

	// ****************************************************************
	// Timebase: shared line or internal oscillator
	// ****************************************************************
	logic share_tick;
	logic time_tick;
	logic osc_tick_q;
	logic [9:0] osc_cnt_q;
	logic [LOSS_W-1:0] loss_cnt_q;

	assign share_tick = share_s2_q && !share_s3_q;
	assign time_tick = share_present_o ? share_tick : osc_tick_q;

	// Internal oscillator tick every 10 us
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_cnt_q <= 10'h000;
			osc_tick_q <= 1'b0;
		end else if (osc_cnt_q == OSC_LAST) begin
			osc_cnt_q <= 10'h000;
			osc_tick_q <= 1'b1;
		end else begin
			osc_cnt_q <= osc_cnt_q + 10'h001;
			osc_tick_q <= 1'b0;
		end
	end

	// Shared line counts as present while its edges keep coming
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			loss_cnt_q <= LOSS_CYC;
			share_present_o <= 1'b0;
		end else if (share_tick) begin
			loss_cnt_q <= '0;
			share_present_o <= 1'b1;
		end else if (loss_cnt_q != LOSS_CYC) begin
			loss_cnt_q <= loss_cnt_q + 1'b1;
		end else begin
			share_present_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Command words
	// ****************************************************************
	logic [15:0] words_q [NC][NW];
	logic [15:0] cfg_q [NC];
	logic cmd_word;
	logic cmd_limit_dropped;
	logic [15:0] cfg_wdata;

	assign cmd_word = link.cmd_code < 8'(NW);

	// Output OV/UV limits vanish on odd channels measuring current
	always_comb begin
		cmd_limit_dropped = 1'b0;
		if (link.cmd_page[0] && cfg_q[link.cmd_page][sps_pkg::CFG_CURRENT_BIT]) begin
			unique case (link.cmd_code)
				sps_pkg::CMD_OUTPUT_OVERVOLTAGE_FAULT_LEVEL,
				sps_pkg::CMD_OUTPUT_OVERVOLTAGE_WARN_LEVEL,
				sps_pkg::CMD_OUTPUT_UNDERVOLTAGE_WARN_LEVEL,
				sps_pkg::CMD_OUTPUT_UNDERVOLTAGE_FAULT_LEVEL: cmd_limit_dropped = 1'b1;
				default: cmd_limit_dropped = 1'b0;
			endcase
		end
	end

	// Current mode is only storable on odd channels
	always_comb begin
		cfg_wdata = link.cmd_wdata;
		if (!link.cmd_page[0]) begin
			cfg_wdata[sps_pkg::CFG_CURRENT_BIT] = 1'b0;
		end
	end

	// Word storage, kept exactly as written
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int c = 0; c < NC; c++) begin
				for (int w = 0; w < NW; w++) begin
					words_q[c][w] <= sps_pkg::WORD_RESET;
				end
			end
		end else if (link.cmd_valid && link.cmd_write && cmd_word && !cmd_limit_dropped) begin
			words_q[link.cmd_page][link.cmd_code[4:0]] <= link.cmd_wdata;
		end
	end

	// Channel configuration
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int c = 0; c < NC; c++) begin
				cfg_q[c] <= sps_pkg::CFG_RESET;
			end
		end else if (link.cmd_valid && link.cmd_write
			&& link.cmd_code == sps_pkg::CMD_CHANNEL_CONFIG) begin
			cfg_q[link.cmd_page] <= cfg_wdata;
		end
	end

	// ****************************************************************
	// Channel sequencers
	// ****************************************************************
	logic [7:0] soft_q;
	logic [7:0] unmask_q;
	logic [7:0] fault_q;
	sps_pkg::sps_seq_state_t seq_state [NC];

	for (genvar g = 0; g < NC; g++) begin : g_chan
		logic on_req;
		logic fast_off_now;
		logic [sps_pkg::TICK_W-1:0] t_on;
		logic [sps_pkg::TICK_W-1:0] t_rise;
		logic [sps_pkg::TICK_W-1:0] t_max;
		logic [sps_pkg::TICK_W-1:0] t_off;

		assign on_req = ctrl_s2_q[g] && cfg_q[g][sps_pkg::CFG_OP_ON_BIT];
		assign fast_off_now = cfg_q[g][sps_pkg::CFG_FAST_OFF_BIT] && !ctrl_s2_q[g];
		// Clamped and rounded copies feed only the timers
		assign t_on = sps_pkg::lin11_to_ticks(words_q[g][sps_pkg::CMD_ENABLE_WAIT_TIME[4:0]],
			1'b1);
		assign t_off = sps_pkg::lin11_to_ticks(words_q[g][sps_pkg::CMD_DISABLE_WAIT_TIME[4:0]],
			1'b1);
		assign t_rise = sps_pkg::lin11_to_ticks(
			words_q[g][sps_pkg::CMD_SOFT_CONNECT_WAIT_TIME[4:0]], 1'b0);
		assign t_max = sps_pkg::lin11_to_ticks(words_q[g][sps_pkg::CMD_POWER_UP_TIMEOUT[4:0]],
			1'b0);

		sps_chan_seq u_seq (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.share_tick_i(share_tick),
			.time_tick_i(time_tick),
			.on_req_i(on_req),
			.fast_off_now_i(fast_off_now),
			.servo_ok_i(cfg_q[g][sps_pkg::CFG_SERVO_LSB +: 2] == sps_pkg::SERVO_SOFT_CONNECT),
			.uv_reached_i(uv_s2_q[g]),
			.ton_delay_i(t_on),
			.ton_rise_i(t_rise),
			.ton_max_i(t_max),
			.toff_delay_i(t_off),
			.enable_o(conv_enable_o[g]),
			.soft_connect_o(soft_q[g]),
			.uv_unmask_o(unmask_q[g]),
			.timeout_fault_o(fault_q[g]),
			.state_o(seq_state[g])
		);
	end

	assign link.conv_enable = conv_enable_o;
	assign link.soft_connect = soft_q;
	assign link.uv_unmask = unmask_q;
	assign link.timeout_fault = fault_q;

	// ****************************************************************
	// Read answers
	// ****************************************************************
	logic [15:0] rd_data;
	logic rd_err;

	// Read mux for the addressed channel
	always_comb begin
		rd_data = 16'h0000;
		rd_err = 1'b0;
		if (cmd_word && !cmd_limit_dropped) begin
			rd_data = words_q[link.cmd_page][link.cmd_code[4:0]];
		end else if (cmd_word) begin
			rd_err = 1'b1;
		end else if (link.cmd_code == sps_pkg::CMD_OUTPUT_MODE) begin
			rd_data = {8'h00, sps_pkg::MODE_TYPE_LINEAR, sps_pkg::MODE_EXPONENT};
		end else if (link.cmd_code == sps_pkg::CMD_CHANNEL_CONFIG) begin
			rd_data = cfg_q[link.cmd_page];
		end else if (link.cmd_code == sps_pkg::CMD_CHANNEL_STATUS) begin
			rd_data = {8'h00, share_present_o, seq_state[link.cmd_page],
				fault_q[link.cmd_page], unmask_q[link.cmd_page],
				soft_q[link.cmd_page], conv_enable_o[link.cmd_page]};
		end else begin
			rd_err = 1'b1;
		end
	end

	// One-cycle answer to every command
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.rsp_valid <= 1'b0;
			link.rsp_err <= 1'b0;
			link.rsp_rdata <= 16'h0000;
		end else begin
			link.rsp_valid <= link.cmd_valid;
			link.rsp_err <= link.cmd_valid && (rd_err
				|| link.cmd_write && link.cmd_code == sps_pkg::CMD_OUTPUT_MODE);
			link.rsp_rdata <= (link.cmd_valid && !link.cmd_write) ? rd_data : 16'h0000;
		end
	end
endmodule // sps_device

`default_nettype wire

// ---- design/sps_pkg.sv ----
package sps_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int unsigned NUM_CHAN = 8;
	localparam int unsigned NUM_WORDS = 24;
	localparam int unsigned PAGE_W = 3;
	localparam int unsigned TICK_W = 21;

	// ****************************************************************
	// Command codes (word index per channel below 8'h18)
	// ****************************************************************
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SETPOINT = 8'h00;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_CEILING = 8'h01;
	localparam logic [7:0] CMD_OUTPUT_MARGIN_UPPER = 8'h02;
	localparam logic [7:0] CMD_OUTPUT_MARGIN_LOWER = 8'h03;
	localparam logic [7:0] CMD_OUTPUT_OVERVOLTAGE_FAULT_LEVEL = 8'h04;
	localparam logic [7:0] CMD_OUTPUT_OVERVOLTAGE_WARN_LEVEL = 8'h05;
	localparam logic [7:0] CMD_OUTPUT_UNDERVOLTAGE_WARN_LEVEL = 8'h06;
	localparam logic [7:0] CMD_OUTPUT_UNDERVOLTAGE_FAULT_LEVEL = 8'h07;
	localparam logic [7:0] CMD_OUTPUT_GOOD_RISING_LEVEL = 8'h08;
	localparam logic [7:0] CMD_OUTPUT_GOOD_FALLING_LEVEL = 8'h09;
	localparam logic [7:0] CMD_INPUT_TURN_ON_LEVEL = 8'h0a;
	localparam logic [7:0] CMD_INPUT_TURN_OFF_LEVEL = 8'h0b;
	localparam logic [7:0] CMD_INPUT_OVERVOLTAGE_FAULT_LEVEL = 8'h0c;
	localparam logic [7:0] CMD_INPUT_OVERVOLTAGE_WARN_LEVEL = 8'h0d;
	localparam logic [7:0] CMD_INPUT_UNDERVOLTAGE_WARN_LEVEL = 8'h0e;
	localparam logic [7:0] CMD_INPUT_UNDERVOLTAGE_FAULT_LEVEL = 8'h0f;
	localparam logic [7:0] CMD_HOT_FAULT_LEVEL = 8'h10;
	localparam logic [7:0] CMD_HOT_WARN_LEVEL = 8'h11;
	localparam logic [7:0] CMD_COLD_WARN_LEVEL = 8'h12;
	localparam logic [7:0] CMD_COLD_FAULT_LEVEL = 8'h13;
	localparam logic [7:0] CMD_ENABLE_WAIT_TIME = 8'h14;
	localparam logic [7:0] CMD_SOFT_CONNECT_WAIT_TIME = 8'h15;
	localparam logic [7:0] CMD_POWER_UP_TIMEOUT = 8'h16;
	localparam logic [7:0] CMD_DISABLE_WAIT_TIME = 8'h17;
	localparam logic [7:0] CMD_OUTPUT_MODE = 8'h18;
	localparam logic [7:0] CMD_CHANNEL_CONFIG = 8'h19;
	localparam logic [7:0] CMD_CHANNEL_STATUS = 8'h1a;

	// ****************************************************************
	// Field layouts and reset values
	// ****************************************************************
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [2:0] MODE_TYPE_LINEAR = 3'h0;
	localparam logic [4:0] MODE_EXPONENT = 5'h13;
	localparam int unsigned CFG_FAST_OFF_BIT = 0;
	localparam int unsigned CFG_CURRENT_BIT = 1;
	localparam int unsigned CFG_OP_ON_BIT = 2;
	localparam int unsigned CFG_SERVO_LSB = 3;
	localparam logic [1:0] SERVO_SOFT_CONNECT = 2'h0;
	localparam int unsigned L11_EXP_LSB = 11;
	localparam int unsigned L11_SIGN_BIT = 10;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TICK_US = 10;
	localparam int unsigned TICK_CYC = (TICK_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned SHARE_LOSS_US = 25;
	localparam int unsigned SHARE_LOSS_CYC = (SHARE_LOSS_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_MS = 1000 / TICK_US;
	localparam int unsigned SHORT_LIMIT_MS = 655;
	localparam int unsigned LONG_LIMIT_MS = 13100;
	localparam int unsigned LONG_STEP_US = 200;
	localparam int unsigned SHORT_MAX_TICKS = SHORT_LIMIT_MS * TICKS_PER_MS;
	localparam int unsigned LONG_MAX_TICKS = LONG_LIMIT_MS * TICKS_PER_MS;
	localparam int unsigned LONG_STEP_TICKS = LONG_STEP_US / TICK_US;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		SEQ_OFF = 3'b000,
		SEQ_DELAY = 3'b001,
		SEQ_ON = 3'b010,
		SEQ_OFF_WAIT = 3'b011
	} sps_seq_state_t;

	// Linear11 milliseconds to timebase ticks, clamped and rounded
	function automatic logic [TICK_W-1:0] lin11_to_ticks(input logic [15:0] w,
		input logic long_form);
		logic [63:0] p;
		logic [63:0] v;
		logic [4:0] sh;
		p = 64'(w[L11_SIGN_BIT-1:0]) * 64'(TICKS_PER_MS);
		sh = 5'(~w[15:L11_EXP_LSB] + 5'h01);
		if (w[L11_SIGN_BIT]) begin
			p = 64'h0;
		end
		if (!w[15]) begin
			v = p << w[15:L11_EXP_LSB];
		end else begin
			v = (p + (64'h1 << (sh - 5'h01))) >> sh;
		end
		if (long_form && v > 64'(SHORT_MAX_TICKS)) begin
			v = ((v + 64'(LONG_STEP_TICKS / 2)) / 64'(LONG_STEP_TICKS)) * 64'(LONG_STEP_TICKS);
		end
		if (long_form && v > 64'(LONG_MAX_TICKS)) begin
			v = 64'(LONG_MAX_TICKS);
		end else if (!long_form && v > 64'(SHORT_MAX_TICKS)) begin
			v = 64'(SHORT_MAX_TICKS);
		end
		return v[TICK_W-1:0];
	endfunction

endpackage

// ---- design/sps_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface sps_link_if;
	logic cmd_valid;
	logic cmd_write;
	logic [2:0] cmd_page;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata;
	logic rsp_valid;
	logic rsp_err;
	logic [15:0] rsp_rdata;
	logic [7:0] channel_control_pin;
	logic share_clk;
	logic [7:0] uv_reached;
	logic [7:0] conv_enable;
	logic [7:0] soft_connect;
	logic [7:0] uv_unmask;
	logic [7:0] timeout_fault;

	modport device (
		input cmd_valid, cmd_write, cmd_page, cmd_code, cmd_wdata,
		input channel_control_pin, share_clk, uv_reached,
		output rsp_valid, rsp_err, rsp_rdata,
		output conv_enable, soft_connect, uv_unmask, timeout_fault
	);

	modport host (
		output cmd_valid, cmd_write, cmd_page, cmd_code, cmd_wdata,
		output channel_control_pin, share_clk, uv_reached,
		input rsp_valid, rsp_err, rsp_rdata,
		input conv_enable, soft_connect, uv_unmask, timeout_fault
	);
endinterface // sps_link_if

`default_nettype wire

// ---- design/sps_chan_seq.sv ----
`timescale 1ns/1ns
`default_nettype none

module sps_chan_seq (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic share_tick_i,
	input wire logic time_tick_i,
	input wire logic on_req_i,
	input wire logic fast_off_now_i,
	input wire logic servo_ok_i,
	input wire logic uv_reached_i,
	input wire logic [sps_pkg::TICK_W-1:0] ton_delay_i,
	input wire logic [sps_pkg::TICK_W-1:0] ton_rise_i,
	input wire logic [sps_pkg::TICK_W-1:0] ton_max_i,
	input wire logic [sps_pkg::TICK_W-1:0] toff_delay_i,
	output logic enable_o,
	output logic soft_connect_o,
	output logic uv_unmask_o,
	output logic timeout_fault_o,
	output sps_pkg::sps_seq_state_t state_o
);
	localparam logic [sps_pkg::TICK_W-1:0] CNT_MAX = '1;

	logic [sps_pkg::TICK_W-1:0] on_cnt_q;
	logic [sps_pkg::TICK_W-1:0] off_cnt_q;

	// ****************************************************************
	// Sequence state
	// ****************************************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_o <= sps_pkg::SEQ_OFF;
		end else begin
			unique case (state_o)
				sps_pkg::SEQ_OFF: begin
					if (on_req_i) state_o <= sps_pkg::SEQ_DELAY;
				end
				sps_pkg::SEQ_DELAY: begin
					if (!on_req_i) state_o <= sps_pkg::SEQ_OFF;
					else if (on_cnt_q >= ton_delay_i) state_o <= sps_pkg::SEQ_ON;
				end
				sps_pkg::SEQ_ON: begin
					if (!on_req_i && fast_off_now_i) state_o <= sps_pkg::SEQ_OFF;
					else if (!on_req_i) state_o <= sps_pkg::SEQ_OFF_WAIT;
				end
				sps_pkg::SEQ_OFF_WAIT: begin
					if (on_req_i) state_o <= sps_pkg::SEQ_ON;
					else if (fast_off_now_i) state_o <= sps_pkg::SEQ_OFF;
					else if (off_cnt_q >= toff_delay_i) state_o <= sps_pkg::SEQ_OFF;
				end
				default: state_o <= sps_pkg::SEQ_OFF;
			endcase
		end
	end

	// Turn-on counter: delay on shared line, then rise and timeout
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			on_cnt_q <= '0;
		end else if (state_o == sps_pkg::SEQ_OFF) begin
			on_cnt_q <= '0;
		end else if (state_o == sps_pkg::SEQ_DELAY) begin
			if (on_cnt_q >= ton_delay_i) on_cnt_q <= '0;
			else if (share_tick_i) on_cnt_q <= on_cnt_q + 1'b1;
		end else if (state_o == sps_pkg::SEQ_ON && time_tick_i && on_cnt_q != CNT_MAX) begin
			on_cnt_q <= on_cnt_q + 1'b1;
		end
	end

	// Turn-off counter
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			off_cnt_q <= '0;
		end else if (state_o != sps_pkg::SEQ_OFF_WAIT) begin
			off_cnt_q <= '0;
		end else if (time_tick_i && off_cnt_q != CNT_MAX) begin
			off_cnt_q <= off_cnt_q + 1'b1;
		end
	end

	// Converter enable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			enable_o <= 1'b0;
		end else if (state_o == sps_pkg::SEQ_DELAY && on_req_i && on_cnt_q >= ton_delay_i) begin
			enable_o <= 1'b1;
		end else if (state_o == sps_pkg::SEQ_OFF || !on_req_i && fast_off_now_i) begin
			enable_o <= 1'b0;
		end else if (state_o == sps_pkg::SEQ_OFF_WAIT && !on_req_i && off_cnt_q >= toff_delay_i) begin
			enable_o <= 1'b0;
		end
	end

	// Soft-connect after rise time
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			soft_connect_o <= 1'b0;
		end else if (!enable_o) begin
			soft_connect_o <= 1'b0;
		end else if (state_o == sps_pkg::SEQ_ON && servo_ok_i && on_cnt_q >= ton_rise_i) begin
			soft_connect_o <= 1'b1;
		end
	end

	// Undervoltage unmask and power-up timeout
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			uv_unmask_o <= 1'b0;
			timeout_fault_o <= 1'b0;
		end else if (state_o == sps_pkg::SEQ_OFF && on_req_i) begin
			uv_unmask_o <= 1'b0;
			timeout_fault_o <= 1'b0;
		end else if (!enable_o) begin
			uv_unmask_o <= 1'b0;
		end else if (state_o == sps_pkg::SEQ_ON && !uv_unmask_o && !timeout_fault_o) begin
			if (uv_reached_i) begin
				uv_unmask_o <= 1'b1;
			end else if (ton_max_i != '0 && on_cnt_q >= ton_max_i) begin
				timeout_fault_o <= 1'b1;
			end
		end
	end
endmodule // sps_chan_seq

`default_nettype wire

// ---- design/sps_host.sv ----
`timescale 1ns/1ns
`default_nettype none

module sps_host #(
	parameter int unsigned SHARE_HALF_CYC = sps_pkg::TICK_CYC / 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	sps_link_if.host link,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [2:0] req_page_i,
	input wire logic [7:0] req_code_i,
	input wire logic [15:0] req_data_i,
	input wire logic share_run_i,
	input wire logic [7:0] control_i,
	input wire logic [7:0] uv_reached_i,
	output logic req_ready_o,
	output logic resp_valid_o,
	output logic resp_err_o,
	output logic [15:0] resp_data_o,
	output logic [7:0] enable_o,
	output logic [7:0] fault_o
);
	localparam logic [15:0] HALF_LAST = 16'(SHARE_HALF_CYC - 1);

	logic [15:0] share_cnt_q;
	logic [7:0] en_s1_q;
	logic [7:0] fault_s1_q;

	// ****************************************************************
	// Shared timebase divider
	// ****************************************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			share_cnt_q <= 16'h0000;
			link.share_clk <= 1'b0;
		end else if (!share_run_i) begin
			share_cnt_q <= 16'h0000;
			link.share_clk <= 1'b0;
		end else if (share_cnt_q == HALF_LAST) begin
			share_cnt_q <= 16'h0000;
			link.share_clk <= !link.share_clk;
		end else begin
			share_cnt_q <= share_cnt_q + 16'h0001;
		end
	end

	// Control pins and converter feedback
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.channel_control_pin <= 8'h00;
			link.uv_reached <= 8'h00;
		end else begin
			link.channel_control_pin <= control_i;
			link.uv_reached <= uv_reached_i;
		end
	end

	// ****************************************************************
	// Command issue: one outstanding request
	// ****************************************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_ready_o <= 1'b1;
			link.cmd_valid <= 1'b0;
			link.cmd_write <= 1'b0;
			link.cmd_page <= 3'h0;
			link.cmd_code <= 8'h00;
			link.cmd_wdata <= 16'h0000;
		end else if (req_valid_i && req_ready_o) begin
			req_ready_o <= 1'b0;
			link.cmd_valid <= 1'b1;
			link.cmd_write <= req_write_i;
			link.cmd_page <= req_page_i;
			link.cmd_code <= req_code_i;
			link.cmd_wdata <= req_data_i;
		end else begin
			link.cmd_valid <= 1'b0;
			if (link.rsp_valid) req_ready_o <= 1'b1;
		end
	end

	// Answer capture
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			resp_valid_o <= 1'b0;
			resp_err_o <= 1'b0;
			resp_data_o <= 16'h0000;
		end else begin
			resp_valid_o <= link.rsp_valid;
			if (link.rsp_valid) begin
				resp_err_o <= link.rsp_err;
				resp_data_o <= link.rsp_rdata;
			end
		end
	end

	// Enable and fault pins from the device, synchronised
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_s1_q <= 8'h00;
			enable_o <= 8'h00;
			fault_s1_q <= 8'h00;
			fault_o <= 8'h00;
		end else begin
			en_s1_q <= link.conv_enable;
			enable_o <= en_s1_q;
			fault_s1_q <= link.timeout_fault;
			fault_o <= fault_s1_q;
		end
	end
endmodule // sps_host

`default_nettype wire

// ---- bench/sps_link_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module sps_link_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [2:0] cmd_page,
	input wire logic [7:0] cmd_code,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic [15:0] rsp_rdata,
	input wire logic [7:0] conv_enable,
	input wire logic [7:0] timeout_fault
);
	// ****************
	// Command answers
	// ****************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ans_delay_a: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
	ans_cause_a: assert property (rsp_valid |-> $past(cmd_valid)) else $error("stray answer");
	ans_single_a: assert property (rsp_valid |=> !rsp_valid) else $error("long answer");
	wr_zero_a: assert property (cmd_valid && cmd_write |=> rsp_rdata == 16'h0) else $error("data");
	mode_read_a: assert property (cmd_valid && !cmd_write && cmd_code == 8'h18 |=>
		rsp_rdata == 16'h0013 && !rsp_err) else $error("mode word");
	mode_write_a: assert property (cmd_valid && cmd_write && cmd_code == 8'h18 |=> rsp_err)
		else $error("mode write");
	bad_code_a: assert property (cmd_valid && cmd_code > 8'h1a |=> rsp_err) else $error("code");
	word_ok_a: assert property (cmd_valid && !cmd_page[0] && cmd_code < 8'h18 |=> !rsp_err)
		else $error("word refused");
	cover property (cmd_valid && cmd_write);
	cover property ($rose(conv_enable[0]));
	cover property ($rose(timeout_fault[0]));
endmodule // sps_link_monitor
`default_nettype wire

// ---- bench/sps_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module channel_limits_and_sequence_timers_tb_top;
	// ****************
	// Bench
	// ****************
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic req_valid_i = 1'h0;
	logic req_write_i = 1'h0;
	logic [2:0] req_page_i = 3'h0;
	logic [7:0] req_code_i = 8'h00;
	logic [15:0] req_data_i = 16'h0000;
	logic [7:0] control_i = 8'h00;
	logic [7:0] uv_reached_i = 8'h00;
	logic share_run_i = 1'h1;
	logic req_ready_o, resp_valid_o, resp_err_o;
	logic [15:0] resp_data_o, w;
	logic [7:0] enable_o, fault_o;
	logic [2:0] pg;
	logic [16:0] exp_q [$];
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	sps_link_if sps_link_if_i ();
	sps_host #(.SHARE_HALF_CYC(4)) sps_host_i (.clk_i(clk_i), .rst_i(rst_i), .link(sps_link_if_i),
		.req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_page_i(req_page_i),
		.req_code_i(req_code_i), .req_data_i(req_data_i), .share_run_i(share_run_i),
		.control_i(control_i), .uv_reached_i(uv_reached_i), .req_ready_o(req_ready_o),
		.resp_valid_o(resp_valid_o), .resp_err_o(resp_err_o), .resp_data_o(resp_data_o),
		.enable_o(enable_o), .fault_o(fault_o));
	sps_device sps_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(sps_link_if_i),
		.conv_enable_o(), .share_present_o());
	sps_link_monitor sps_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
		.cmd_valid(sps_link_if_i.cmd_valid), .cmd_write(sps_link_if_i.cmd_write),
		.cmd_page(sps_link_if_i.cmd_page), .cmd_code(sps_link_if_i.cmd_code),
		.rsp_valid(sps_link_if_i.rsp_valid), .rsp_err(sps_link_if_i.rsp_err),
		.rsp_rdata(sps_link_if_i.rsp_rdata), .conv_enable(sps_link_if_i.conv_enable),
		.timeout_fault(sps_link_if_i.timeout_fault));
	// Clock
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	task chk(input string n, input logic [16:0] e, input logic [16:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task close_out;
		chk("pending", 17'h0, 17'(exp_q.size()));
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One request, held until taken; answer noted in the queue
	task xfer(input logic wr, input logic [2:0] p, input logic [7:0] c, input logic [15:0] d,
		input logic [16:0] e);
		exp_q.push_back(e);
		req_valid_i <= 1'h1;
		req_write_i <= wr;
		req_page_i <= p;
		req_code_i <= c;
		req_data_i <= d;
		do @(posedge clk_i); while (req_ready_o !== 1'h1);
		req_valid_i <= 1'h0;
		@(posedge clk_i);
	endtask
	// Level seen after n cycles, settled at the falling edge
	task look(input int n, input string s, input logic [7:0] e);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
		chk(s, 17'(e), {9'h0, enable_o[0] ? 8'h01 : 8'h00} | {9'h0, fault_o[0] ? 8'h02 : 8'h00});
		@(posedge clk_i);
	endtask
	// Answer watcher
	always @(posedge clk_i) begin
		if (resp_valid_o === 1'h1) begin
			chk("answer", exp_q.size() > 0 ? exp_q.pop_front() : 17'h1ffff,
				{resp_err_o, resp_data_o});
		end
	end
	// Hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		void'($urandom(32'hb42686c8));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		for (int c = 0; c < 24; c++) begin
			pg = 3'($urandom_range(7));
			w = 16'($urandom());
			xfer(1'h1, pg, 8'(c), w, 17'h0);
			xfer(1'h0, pg, 8'(c), 16'h0, {1'h0, w});
		end
		xfer(1'h0, 3'h0, 8'h18, 16'h0, 17'h0013);
		xfer(1'h1, 3'h0, 8'h18, 16'h1234, 17'h10000);
		xfer(1'h0, 3'h0, 8'h1b, 16'h0, 17'h10000);
		xfer(1'h1, 3'h1, 8'h19, 16'h0002, 17'h0);
		xfer(1'h1, 3'h1, 8'h04, 16'h1234, 17'h10000);
		xfer(1'h0, 3'h1, 8'h07, 16'h0, 17'h10000);
		xfer(1'h1, 3'h0, 8'h14, 16'h0001, 17'h0);
		xfer(1'h1, 3'h0, 8'h16, 16'h0001, 17'h0);
		xfer(1'h1, 3'h0, 8'h17, 16'h03ff, 17'h0);
		xfer(1'h1, 3'h0, 8'h19, 16'h0004, 17'h0);
		control_i <= 8'h01;
		look(780, "enable early", 8'h00);
		look(50, "enable", 8'h01);
		look(900, "timeout", 8'h03);
		xfer(1'h1, 3'h0, 8'h19, 16'h0005, 17'h0);
		control_i <= 8'h00;
		look(8, "fast off", 8'h02);
		// Zero delay and zero timeout, rise time and off delay of 1 ms
		xfer(1'h1, 3'h0, 8'h14, 16'h0000, 17'h0);
		xfer(1'h1, 3'h0, 8'h15, 16'h0001, 17'h0);
		xfer(1'h1, 3'h0, 8'h16, 16'h0000, 17'h0);
		xfer(1'h1, 3'h0, 8'h17, 16'h0001, 17'h0);
		xfer(1'h1, 3'h0, 8'h19, 16'h0004, 17'h0);
		control_i <= 8'h01;
		look(900, "no timeout", 8'h01);
		xfer(1'h0, 3'h0, 8'h1a, 16'h0, 17'h00a3);
		uv_reached_i <= 8'h01;
		look(8, "unmask", 8'h01);
		xfer(1'h0, 3'h0, 8'h1a, 16'h0, 17'h00a7);
		control_i <= 8'h00;
		look(700, "off delay", 8'h01);
		look(150, "off", 8'h00);
		// Shared line stopped: internal ticks, 0.125 ms rounds to 13 ticks
		share_run_i <= 1'h0;
		xfer(1'h1, 3'h0, 8'h17, 16'he801, 17'h0);
		control_i <= 8'h01;
		look(1400, "osc on", 8'h01);
		xfer(1'h0, 3'h0, 8'h1a, 16'h0, 17'h0025);
		control_i <= 8'h00;
		look(5900, "osc off wait", 8'h01);
		look(640, "osc off", 8'h00);
		close_out();
	end
endmodule // channel_limits_and_sequence_timers_tb_top
`default_nettype wire
